/* File: include/isc_regs.vh */
// Register offsets, field positions and reset values of the I2C/SMBus control block.
// Operation
// - Seven event flags are ORed onto the event interrupt, gated by event_irq_on.
// - tx_empty and rx_full interrupt only with buffer_irq_on, whatever dma_request_on.
// - Seven error flags are ORed onto the error interrupt, gated by error_irq_on.
// - During debug halt, timeout counting runs or freezes per debug_timeout_freeze.
// - Registers accept both half-word and word accesses.
// - While soft_reset is 1, the whole interface is held in reset.
// - alert_drive pulls alert_line low and ACKs alert header; cleared when block_on is 0.
// - CRC request cleared after CRC transfer, START, STOP, or when block_on is 0.
// - ack_lookahead selects whether ACK and CRC apply to current or next byte.
// - Acknowledge enable returns ACK after received bytes; cleared when block_on is 0.
// - Stop request set on timeout, cleared on STOP; master generates STOP.
// - In slave mode a stop request releases clock and data after the byte.
// - Start request makes START; cleared when sent or block_on is 0.
// - hold_clock_disable stops slave clock stretching on matched or byte-done.
// - general_call_accept ACKs address 00h; crc8_check_on enables CRC computation.
// - arp_address_accept recognises device default or host address per host_role_select.
// - protocol_variant_select picks I2C or SMBus; block_on enables and routes pins.
// - Clearing block_on mid-transfer defers disable and its bit resets until idle.
// - dma_final_block marks next DMA end-of-transfer as last, NACKing final byte in master mode.
// - dma_request_on issues DMA requests whenever tx_empty or rx_full is 1.
`ifndef ISC_REGS_VH
`define ISC_REGS_VH
`define ISC_OFS_CONTROL_ONE 4'h0
`define ISC_OFS_CONTROL_TWO 4'h4
`define ISC_RST_CONTROL_ONE 16'h0000
`define ISC_RST_CONTROL_TWO 16'h0000
`define ISC_C1_SOFT_RESET 15
`define ISC_C1_ALERT_DRIVE 13
`define ISC_C1_CRC8_REQ 12
`define ISC_C1_ACK_LOOKAHEAD 11
`define ISC_C1_ACK_ENABLE 10
`define ISC_C1_STOP_REQ 9
`define ISC_C1_START_REQ 8
`define ISC_C1_HOLD_CLOCK_DIS 7
`define ISC_C1_GENERAL_CALL 6
`define ISC_C1_CRC8_CHECK_ON 5
`define ISC_C1_ARP_ACCEPT 4
`define ISC_C1_HOST_ROLE 3
`define ISC_C1_PROTOCOL_VAR 1
`define ISC_C1_BLOCK_ON 0
`define ISC_C1_WRITABLE 16'hBFFB
`define ISC_C2_DMA_FINAL 12
`define ISC_C2_DMA_REQ_ON 11
`define ISC_C2_BUFFER_IRQ 10
`define ISC_C2_EVENT_IRQ 9
`define ISC_C2_ERROR_IRQ 8
`define ISC_C2_WRITABLE 16'h1F3F
`endif

/* File: logic/isc_control_irq.v */
// Control registers, interrupt mapping and DMA request logic of the I2C/SMBus block.
`timescale 1ns/1ps
`include "isc_regs.vh"

module isc_control_irq (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Avalon-MM slave
  input wire [3:0] avs_address_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Event flags from the status logic
  input wire start_sent_flag_i,
  input wire target_matched_flag_i,
  input wire ten_bit_header_flag_i,
  input wire stop_seen_flag_i,
  input wire byte_done_flag_i,
  input wire rx_full_flag_i,
  input wire tx_empty_flag_i,
  // Error flags from the status logic
  input wire bus_fault_flag_i,
  input wire arbitration_lost_flag_i,
  input wire ack_failure_flag_i,
  input wire overrun_flag_i,
  input wire crc8_mismatch_flag_i,
  input wire clock_low_overtime_flag_i,
  input wire alert_event_flag_i,
  // Protocol engine status
  input wire master_mode_i,
  input wire crc_sent_i,
  input wire start_done_i,
  input wire timeout_error_i,
  input wire dma_eot_i,
  // Debug
  input wire debug_halt_i,
  input wire debug_timeout_freeze_i,
  // Bus lines, sampled
  input wire scl_i,
  input wire sda_i,
  // Alert line, open drain
  input wire alert_line_i,
  output reg alert_line_o,
  output reg alert_line_oe_o,
  // Interrupts and DMA
  output reg event_irq_o,
  output reg error_irq_o,
  output reg dma_req_o,
  // Controls to the protocol engine
  output reg engine_reset_o,
  output reg pins_enabled_o,
  output reg smbus_mode_o,
  output reg ack_enable_o,
  output reg ack_next_byte_o,
  output reg crc_request_o,
  output reg crc_enable_o,
  output reg gen_stop_o,
  output reg release_lines_o,
  output reg gen_start_o,
  output reg stretch_allowed_o,
  output reg general_call_ack_o,
  output reg accept_default_addr_o,
  output reg accept_host_addr_o,
  output reg alert_header_ack_o,
  output reg nack_last_byte_o,
  output reg timeout_run_o
);

  // ***************************************************************
  // Bus line synchronisers and START/STOP detection
  // ***************************************************************
  reg scl_meta;
  reg scl_sync;
  reg sda_meta;
  reg sda_sync;
  reg sda_prev;
  reg bus_busy;
  reg alert_meta;
  reg alert_sync;
  wire start_seen;
  wire stop_seen;

  always @(posedge clk_i) begin
    if (reset_i) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      alert_meta <= 1'b1;
      alert_sync <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      alert_meta <= alert_line_i;
      alert_sync <= alert_meta;
    end
  end

  assign start_seen = scl_sync & sda_prev & ~sda_sync;
  assign stop_seen = scl_sync & ~sda_prev & sda_sync;

  // ***************************************************************
  // Avalon-MM handshake
  // ***************************************************************
  // One wait state: the read word is latched while waitrequest is high,
  // and a write lands on the edge where waitrequest is low.
  reg resp;
  wire req;
  wire wr_take;
  reg [15:0] control_one;
  reg [15:0] control_two;
  reg block_on_eff;
  wire soft_reset;
  wire [15:0] lane_mask;
  wire [15:0] c1_mask;
  wire [15:0] c2_mask;
  wire wr_c1;
  wire wr_c2;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~resp;
  assign wr_take = avs_write_i & resp;
  // Half-word and word writes both reach the low 16 bits through lanes 0 and 1.
  assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign c1_mask = lane_mask & `ISC_C1_WRITABLE;
  assign c2_mask = lane_mask & `ISC_C2_WRITABLE;
  assign wr_c1 = wr_take & (avs_address_i == `ISC_OFS_CONTROL_ONE);
  assign wr_c2 = wr_take & (avs_address_i == `ISC_OFS_CONTROL_TWO);
  assign soft_reset = control_one[`ISC_C1_SOFT_RESET];

  always @(posedge clk_i) begin
    if (reset_i) begin
      resp <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      resp <= req & ~resp;
      if (avs_read_i & ~resp) begin
        case (avs_address_i)
          `ISC_OFS_CONTROL_ONE: avs_readdata_o <= {16'h0000, control_one};
          `ISC_OFS_CONTROL_TWO: avs_readdata_o <= {16'h0000, control_two};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Bus activity and deferred disable
  // ***************************************************************
  // Clearing block_on only takes hold once the bus is idle, so a transfer
  // in flight is never cut and its bit resets wait with it.
  always @(posedge clk_i) begin
    if (reset_i | soft_reset) begin
      bus_busy <= 1'b0;
      block_on_eff <= 1'b0;
    end else begin
      if (start_seen) begin
        bus_busy <= 1'b1;
      end else if (stop_seen) begin
        bus_busy <= 1'b0;
      end
      if (control_one[`ISC_C1_BLOCK_ON]) begin
        block_on_eff <= 1'b1;
      end else if (~bus_busy & ~start_seen) begin
        block_on_eff <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Control register one
  // ***************************************************************
  reg [15:0] next_control_one;

  always @* begin
    next_control_one = control_one;
    if (wr_c1) begin
      next_control_one = (control_one & ~c1_mask) | (avs_writedata_i[15:0] & c1_mask);
    end
    if (control_one[`ISC_C1_CRC8_REQ] & (crc_sent_i | start_seen | stop_seen)) begin
      next_control_one[`ISC_C1_CRC8_REQ] = 1'b0;
    end
    if (control_one[`ISC_C1_START_REQ] & start_done_i) begin
      next_control_one[`ISC_C1_START_REQ] = 1'b0;
    end
    if (stop_seen) begin
      next_control_one[`ISC_C1_STOP_REQ] = 1'b0;
    end
    // A timeout in the same cycle as a write or a STOP still sets the request.
    if (timeout_error_i) begin
      next_control_one[`ISC_C1_STOP_REQ] = 1'b1;
    end
    // The new block_on value decides, so enabling and setting a bit in one write keeps the bit.
    if (~block_on_eff & ~next_control_one[`ISC_C1_BLOCK_ON]) begin
      next_control_one[`ISC_C1_ALERT_DRIVE] = 1'b0;
      next_control_one[`ISC_C1_CRC8_REQ] = 1'b0;
      next_control_one[`ISC_C1_ACK_LOOKAHEAD] = 1'b0;
      next_control_one[`ISC_C1_ACK_ENABLE] = 1'b0;
      next_control_one[`ISC_C1_START_REQ] = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      control_one <= `ISC_RST_CONTROL_ONE;
    end else if (soft_reset) begin
      // Only the soft reset bit itself stays writable while held.
      control_one <= `ISC_RST_CONTROL_ONE;
      if (wr_c1 & c1_mask[`ISC_C1_SOFT_RESET]) begin
        control_one[`ISC_C1_SOFT_RESET] <= avs_writedata_i[`ISC_C1_SOFT_RESET];
      end else begin
        control_one[`ISC_C1_SOFT_RESET] <= 1'b1;
      end
    end else begin
      control_one <= next_control_one;
    end
  end

  // ***************************************************************
  // Control register two and the last-transfer NACK
  // ***************************************************************
  reg last_armed;

  always @(posedge clk_i) begin
    if (reset_i | soft_reset) begin
      control_two <= `ISC_RST_CONTROL_TWO;
      last_armed <= 1'b0;
    end else begin
      if (wr_c2) begin
        control_two <= (control_two & ~c2_mask) | (avs_writedata_i[15:0] & c2_mask);
      end
      if (dma_eot_i & control_two[`ISC_C2_DMA_FINAL]) begin
        last_armed <= 1'b1;
      end else if (start_seen | stop_seen) begin
        last_armed <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Interrupts, DMA requests and engine controls
  // ***************************************************************
  wire event_any;
  wire error_any;
  wire c1_on;
  wire slave_mode;

  assign event_any = start_sent_flag_i | target_matched_flag_i | ten_bit_header_flag_i
    | stop_seen_flag_i | byte_done_flag_i
    | (control_two[`ISC_C2_BUFFER_IRQ] & (tx_empty_flag_i | rx_full_flag_i));
  assign error_any = bus_fault_flag_i | arbitration_lost_flag_i | ack_failure_flag_i
    | overrun_flag_i | crc8_mismatch_flag_i | clock_low_overtime_flag_i
    | alert_event_flag_i;
  assign c1_on = block_on_eff & ~soft_reset;
  assign slave_mode = ~master_mode_i;

  always @(posedge clk_i) begin
    if (reset_i) begin
      event_irq_o <= 1'b0;
      error_irq_o <= 1'b0;
      dma_req_o <= 1'b0;
      engine_reset_o <= 1'b1;
      pins_enabled_o <= 1'b0;
      smbus_mode_o <= 1'b0;
      ack_enable_o <= 1'b0;
      ack_next_byte_o <= 1'b0;
      crc_request_o <= 1'b0;
      crc_enable_o <= 1'b0;
      gen_stop_o <= 1'b0;
      release_lines_o <= 1'b0;
      gen_start_o <= 1'b0;
      stretch_allowed_o <= 1'b1;
      general_call_ack_o <= 1'b0;
      accept_default_addr_o <= 1'b0;
      accept_host_addr_o <= 1'b0;
      alert_header_ack_o <= 1'b0;
      nack_last_byte_o <= 1'b0;
      timeout_run_o <= 1'b1;
      alert_line_o <= 1'b0;
      alert_line_oe_o <= 1'b0;
    end else begin
      event_irq_o <= control_two[`ISC_C2_EVENT_IRQ] & event_any;
      error_irq_o <= control_two[`ISC_C2_ERROR_IRQ] & error_any;
      dma_req_o <= control_two[`ISC_C2_DMA_REQ_ON] & (tx_empty_flag_i | rx_full_flag_i);
      engine_reset_o <= soft_reset | ~block_on_eff;
      pins_enabled_o <= c1_on;
      smbus_mode_o <= control_one[`ISC_C1_PROTOCOL_VAR];
      ack_enable_o <= c1_on & control_one[`ISC_C1_ACK_ENABLE];
      ack_next_byte_o <= control_one[`ISC_C1_ACK_LOOKAHEAD];
      crc_request_o <= c1_on & control_one[`ISC_C1_CRC8_REQ];
      crc_enable_o <= control_one[`ISC_C1_CRC8_CHECK_ON];
      gen_stop_o <= c1_on & master_mode_i & control_one[`ISC_C1_STOP_REQ];
      release_lines_o <= c1_on & slave_mode & control_one[`ISC_C1_STOP_REQ];
      gen_start_o <= c1_on & control_one[`ISC_C1_START_REQ]
        & (master_mode_i | ~bus_busy);
      stretch_allowed_o <= ~control_one[`ISC_C1_HOLD_CLOCK_DIS];
      general_call_ack_o <= control_one[`ISC_C1_GENERAL_CALL];
      accept_default_addr_o <= control_one[`ISC_C1_ARP_ACCEPT]
        & ~control_one[`ISC_C1_HOST_ROLE];
      accept_host_addr_o <= control_one[`ISC_C1_ARP_ACCEPT]
        & control_one[`ISC_C1_HOST_ROLE];
      alert_header_ack_o <= control_one[`ISC_C1_ALERT_DRIVE];
      nack_last_byte_o <= last_armed & master_mode_i;
      timeout_run_o <= ~(debug_halt_i & debug_timeout_freeze_i);
      alert_line_o <= 1'b0;
      alert_line_oe_o <= c1_on & control_one[`ISC_C1_ALERT_DRIVE];
    end
  end

endmodule // isc_control_irq

/* File: bench/isc_control_irq_chk.sv */
// Concurrent checks on the control block's bus, interrupt and debug outputs.
`timescale 1ns/1ps
module isc_control_irq_chk (
  // Clock, reset and bus
  input wire clk_i,
  input wire reset_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // Flags
  input wire rx_full_flag_i,
  input wire tx_empty_flag_i,
  input wire bus_fault_flag_i,
  input wire arbitration_lost_flag_i,
  input wire ack_failure_flag_i,
  input wire overrun_flag_i,
  input wire crc8_mismatch_flag_i,
  input wire clock_low_overtime_flag_i,
  input wire alert_event_flag_i,
  // Debug and outputs
  input wire debug_halt_i,
  input wire debug_timeout_freeze_i,
  input wire alert_line_o,
  input wire alert_line_oe_o,
  input wire event_irq_o,
  input wire error_irq_o,
  input wire dma_req_o,
  input wire engine_reset_o,
  input wire timeout_run_o
);
  wire err = bus_fault_flag_i | arbitration_lost_flag_i | ack_failure_flag_i | overrun_flag_i
    | crc8_mismatch_flag_i | clock_low_overtime_flag_i | alert_event_flag_i;
  wire req = avs_read_i | avs_write_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_err_cause; error_irq_o |-> $past(err); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error irq without flag");
  // A register write moves the enables, so the level is only held across quiet cycles.
  property p_err_lvl;
    error_irq_o && err && !$past(avs_write_i && !avs_waitrequest_o) |=> error_irq_o;
  endproperty
  a_err_lvl: assert property (p_err_lvl) else $error("error irq dropped");
  property p_dma; dma_req_o |-> $past(tx_empty_flag_i | rx_full_flag_i); endproperty
  a_dma: assert property (p_dma) else $error("dma request without flag");
  property p_wait; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_wait_hi; $rose(req) |-> avs_waitrequest_o; endproperty
  a_wait_hi: assert property (p_wait_hi) else $error("answer without wait");
  property p_rd_hi; avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half set");
  property p_tmo;
    1 |=> timeout_run_o == !($past(debug_halt_i) && $past(debug_timeout_freeze_i));
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout run wrong");
  property p_alert; alert_line_oe_o |-> !alert_line_o; endproperty
  a_alert: assert property (p_alert) else $error("alert line driven high");
  property p_eng; $fell(reset_i) |-> engine_reset_o; endproperty
  a_eng: assert property (p_eng) else $error("engine out of reset");
  c_ev: cover property (event_irq_o);
  c_err: cover property (error_irq_o);
  c_dma: cover property (dma_req_o && !event_irq_o);
endmodule // isc_control_irq_chk

bind isc_control_irq isc_control_irq_chk u_chk (.clk_i, .reset_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .rx_full_flag_i, .tx_empty_flag_i, .bus_fault_flag_i,
  .arbitration_lost_flag_i, .ack_failure_flag_i, .overrun_flag_i, .crc8_mismatch_flag_i,
  .clock_low_overtime_flag_i, .alert_event_flag_i, .debug_halt_i, .debug_timeout_freeze_i,
  .alert_line_o, .alert_line_oe_o, .event_irq_o, .error_irq_o, .dma_req_o, .engine_reset_o,
  .timeout_run_o);

/* File: bench/isc_bus_agent.sv */
// Far-side bus agent that frames START, nine clocked bits and STOP on the two wires.
`timescale 1ns/1ps
module isc_bus_agent (
  output reg scl_o,
  output reg sda_o
);
  localparam int HALF = 400;
  // Released lines rest high on their pull-ups; the clock stands still between frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data moves only in the middle of the low clock phase, so no false START or STOP appears.
  task automatic start_frame();
    #10;
    sda_o = 1'b0;
    #HALF scl_o = 1'b0;
    repeat (9) begin
      #(HALF / 2) sda_o = ~sda_o;
      #(HALF / 2) scl_o = 1'b1;
      #HALF scl_o = 1'b0;
    end
  endtask
  task automatic stop_frame();
    #10;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask
endmodule // isc_bus_agent

/* File: bench/i2c_smbus_control_irq_tb.sv */
// Self-checking bench of the control, interrupt and DMA request block.
`timescale 1ns/1ps
module i2c_smbus_control_irq_tb;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [3:0] adr = 4'h0;
  reg [3:0] be = 4'hf;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0000_0000;
  reg [6:0] evf = 7'h00;
  reg [6:0] erf = 7'h00;
  reg [3:0] pls = 4'h0;
  reg hlt = 1'b0;
  reg frz = 1'b0;
  reg mst = 1'b0;
  reg [31:0] got, v, c2, rv, x;
  wire [31:0] rdat;
  wire wreq, oe, evi, eri, dmr, ern, trun, scl, sda;
  wire pen, smb, acke, ackn, crq, crce, gsto, rel, gsta, str, gca, adf, ahs, ahd, nlb;
  integer num_errors = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer i;
  always #50 clk_i = ~clk_i;
  isc_bus_agent agent (.scl_o(scl), .sda_o(sda));
  isc_control_irq dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_byteenable_i(be), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .start_sent_flag_i(evf[0]),
    .target_matched_flag_i(evf[1]), .ten_bit_header_flag_i(evf[2]),
    .stop_seen_flag_i(evf[3]), .byte_done_flag_i(evf[4]), .rx_full_flag_i(evf[5]),
    .tx_empty_flag_i(evf[6]), .bus_fault_flag_i(erf[0]), .arbitration_lost_flag_i(erf[1]),
    .ack_failure_flag_i(erf[2]), .overrun_flag_i(erf[3]), .crc8_mismatch_flag_i(erf[4]),
    .clock_low_overtime_flag_i(erf[5]), .alert_event_flag_i(erf[6]), .master_mode_i(mst),
    .crc_sent_i(pls[0]), .start_done_i(pls[1]), .timeout_error_i(pls[2]),
    .dma_eot_i(pls[3]), .debug_halt_i(hlt), .debug_timeout_freeze_i(frz), .scl_i(scl),
    .sda_i(sda), .alert_line_i(!oe), .alert_line_o(), .alert_line_oe_o(oe),
    .event_irq_o(evi), .error_irq_o(eri), .dma_req_o(dmr), .engine_reset_o(ern),
    .pins_enabled_o(pen), .smbus_mode_o(smb), .ack_enable_o(acke), .ack_next_byte_o(ackn),
    .crc_request_o(crq), .crc_enable_o(crce), .gen_stop_o(gsto), .release_lines_o(rel),
    .gen_start_o(gsta), .stretch_allowed_o(str), .general_call_ack_o(gca),
    .accept_default_addr_o(adf), .accept_host_addr_o(ahs), .alert_header_ack_o(ahd),
    .nack_last_byte_o(nlb), .timeout_run_o(trun));
  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input [31:0] seen, input [31:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // The request holds until a rising edge sees waitrequest low; read data is taken there.
  task automatic bus(input bit w, input [3:0] a, input [3:0] b, input [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    be <= b;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input [3:0] a, input [31:0] want);
    bus(0, a, 4'hf, 32'h0000_0000);
    chk(got, want);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    rv = $urandom(32'he2b5);
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(4'h0, 32'h0000_0000);
    rchk(4'h4, 32'h0000_0000);
    // Pending-request bits stay out of random writes so no request is ever doubled.
    for (i = 0; i < 8; i++) begin
      v = $urandom & 32'h0000_2cfb;
      bus(1, 4'h0, i[0] ? 4'h3 : 4'hf, v);
      repeat (2) @(posedge clk_i);
      x = v[0] ? v : v & 32'h0000_d3ff;
      rchk(4'h0, x);
      chk({pen, smb, acke, ackn, crce, str, gca, adf, ahs, ahd, oe, ern},
        {v[0], x[1], v[0] & x[10], x[11], x[5], !x[7], x[6], x[4] & !x[3], x[4] & x[3], x[13],
        v[0] & x[13], !v[0]});
      v = $urandom;
      bus(1, 4'h4, i[0] ? 4'h3 : 4'hf, v);
      rchk(4'h4, v & 32'h0000_1f3f);
    end
    bus(1, 4'h8, 4'hf, 32'h0000_ffff);
    rchk(4'h8, 32'h0000_0000);
    bus(1, 4'h0, 4'hf, 32'h0000_0001);
    for (i = 0; i < 300; i++) begin
      if (i % 25 == 0) begin
        c2 = $urandom & 32'h0000_0f00;
        bus(1, 4'h4, 4'hf, c2);
      end
      rv = $urandom;
      @(posedge clk_i);
      hlt <= rv[0];
      frz <= rv[1];
      evf <= rv[8:2] & rv[15:9];
      erf <= rv[22:16] & rv[29:23];
      @(posedge clk_i);
      @(negedge clk_i);
      chk(evi, c2[9] & (|evf[4:0] | c2[10] & |evf[6:5]));
      chk(eri, c2[8] & |erf);
      chk(dmr, c2[11] & |evf[6:5]);
      chk(trun, !(hlt & frz));
    end
    @(posedge clk_i);
    evf <= 7'h00;
    erf <= 7'h00;
    hlt <= 1'b0;
    bus(1, 4'h0, 4'hf, 32'h0000_8401);
    rchk(4'h0, 32'h0000_8000);
    rchk(4'h4, 32'h0000_0000);
    chk(ern, 1);
    bus(1, 4'h0, 4'hf, 32'h0000_0000);
    for (i = 0; i < 3; i++) begin
      x = i == 0 ? 32'h0000_1001 : i == 1 ? 32'h0000_0101 : 32'h0000_0001;
      bus(1, 4'h0, 4'hf, x);
      rchk(4'h0, x);
      chk({crq, gsta}, x[12] ? 2 : x[8] ? 1 : 0);
      @(posedge clk_i);
      pls[i] <= 1'b1;
      @(posedge clk_i);
      pls <= 4'h0;
      rchk(4'h0, i == 2 ? 32'h0000_0201 : 32'h0000_0001);
    end
    chk({gsto, rel}, 32'h0000_0001);
    mst <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({gsto, rel}, 32'h0000_0002);
    agent.start_frame();
    agent.stop_frame();
    rchk(4'h0, 32'h0000_0001);
    bus(1, 4'h4, 4'hf, 32'h0000_1000);
    @(posedge clk_i);
    pls[3] <= 1'b1;
    @(posedge clk_i);
    pls <= 4'h0;
    repeat (2) @(posedge clk_i);
    chk(nlb, 1);
    mst <= 1'b0;
    bus(1, 4'h0, 4'hf, 32'h0000_0401);
    agent.start_frame();
    bus(1, 4'h0, 4'hf, 32'h0000_0400);
    rchk(4'h0, 32'h0000_0400);
    agent.stop_frame();
    rchk(4'h0, 32'h0000_0000);
    bus(1, 4'h0, 4'hf, 32'h0000_2001);
    repeat (3) @(negedge clk_i);
    chk(oe, 1);
    bus(1, 4'h0, 4'hf, 32'h0000_2000);
    repeat (3) @(negedge clk_i);
    chk(oe, 0);
    rchk(4'h0, 32'h0000_0000);
    give_verdict();
  end
endmodule // i2c_smbus_control_irq_tb
